// file: bench/sce_core_monitor.sv
`include "sce_map.vh"
`default_nettype none
module sce_core_chk (
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic [3:0]  regAddr,
    input wire logic [15:0] regWdata,
    input wire logic        regWr,
    input wire logic        regRd,
    input wire logic [15:0] regRdata,
    input wire logic [3:0]  padIn,
    input wire logic [3:0]  padOut,
    input wire logic [3:0]  padOe,
    input wire logic [7:0]  rxAddr,
    input wire logic        rxAddrValid,
    input wire logic        addrMatch_ff,
    input wire logic        irqReq
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    ////////////////////////////////
    rdata_idle_a: assert property (!$past(regRd) |-> regRdata == 16'h0000)
        else $error("read data not zero outside answer cycle");
    irq_hold_a: assert property (irqReq && !regWr && !regRd |=> irqReq)
        else $error("interrupt request dropped without access");
    match_cause_a: assert property ($changed(addrMatch_ff) |-> $past(rxAddrValid || regWr))
        else $error("match result changed without capture");
    oe_cause_a: assert property ($changed(padOe) |-> $past(regWr))
        else $error("pad enables changed without write");
    oe_count_a: assert property ($countones(padOe) <= 2)
        else $error("too many pads driven");
    enclr_all_a: assert property (regWr && regAddr == `SCE_REG_IRQ_ENABLE_CLEAR_REGISTER &&
        regWdata[4:0] == 5'h1F |=> !irqReq)
        else $error("request stayed after disabling all");
    swrst_clear_a: assert property (regWr && regAddr == `SCE_REG_CTRLA && regWdata[0]
        |=> padOe == 4'h0 && !irqReq)
        else $error("soft reset left pads or request active");
    match_read_a: assert property (regRd && regAddr == `SCE_REG_MATCH
        |=> regRdata == {15'h0000, $past(addrMatch_ff)})
        else $error("match register read wrong");
    ////////////////////////////////
    cover property ($rose(irqReq));
    cover property ($rose(addrMatch_ff));
    cover property (padOe != 4'h0);
endmodule
bind sce_core sce_core_chk i_chk (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .padIn(padIn),
    .padOut(padOut), .padOe(padOe), .rxAddr(rxAddr), .rxAddrValid(rxAddrValid),
    .addrMatch_ff(addrMatch_ff), .irqReq(irqReq));
`default_nettype wire

// file: bench/sce_core_tb.sv
`include "sce_map.vh"
`default_nettype none
`define CHK(g, e) begin numChecks++; if ((g) !== (e)) begin errors++; \
    $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module sce_core_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        mclk        = 1'b0;
    logic        rst_n       = 1'b0;
    logic [3:0]  regAddr     = 4'h0;
    logic [15:0] regWdata    = 16'h0000;
    logic        regWr       = 1'b0;
    logic        regRd       = 1'b0;
    logic [7:0]  rxAddr      = 8'h00;
    logic        rxAddrValid = 1'b0;
    logic [15:0] regRdata;
    logic [3:0]  padIn;
    logic [3:0]  padOut;
    logic [3:0]  padOe;
    logic        addrMatch_ff;
    logic        irqReq;
    logic        peerLine;
    logic [15:0] rdVal;
    logic [9:0]  txFrame;
    int          errors      = 0;
    int          numChecks   = 0;
    int          cycles      = 0;
    int          n;
    // Fields: mode 29:28, eight-bit 24, mask 23:16, address 15:8, received 7:0.
    logic [31:0] amTab [13]  = '{32'h01005A5A, 32'h01005A5B, 32'h01FF5A03, 32'h010F5A53,
        32'h010F5A6A, 32'h00005ADA, 32'h01005ADA, 32'h11335A33, 32'h11335A34,
        32'h21102010, 32'h21102020, 32'h21102021, 32'h2110200F};

    always #20 mclk = ~mclk;
    // Undriven pads 0 to 2 are pulled up; pad 3 carries the peer line.
    assign padIn = {peerLine, ~padOe[2:0] | padOut[2:0]};
    sce_core i_dut (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .padIn(padIn), .padOut(padOut),
        .padOe(padOe), .rxAddr(rxAddr), .rxAddrValid(rxAddrValid),
        .addrMatch_ff(addrMatch_ff), .irqReq(irqReq));
    sce_peer i_peer (.mclk(mclk), .rxLine(peerLine));
    ////////////////////////////////
    task automatic summarize;
        $display("checks %0d errors %0d", numChecks, errors);
        if (errors == 0 && numChecks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic chkRd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1;
        rdVal = regRdata;
        `CHK(rdVal & m, e)
        @(posedge mclk);
    endtask
    function automatic logic expMatch(input logic [31:0] c);
        logic [7:0] w;
        w = c[24] ? 8'hFF : 8'h7F;
        case (c[29:28])
            2'h0: return ((c[7:0] ^ c[15:8]) & ~c[23:16] & w) == 8'h00;
            2'h1: return (c[7:0] & w) == (c[15:8] & w) || (c[7:0] & w) == (c[23:16] & w);
            default: return (c[7:0] & w) >= (c[23:16] & w) && (c[7:0] & w) <= (c[15:8] & w);
        endcase
    endfunction
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            summarize();
        end
    end
    ////////////////////////////////
    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        #1;
        `CHK({regRdata, padOe, padOut, irqReq, addrMatch_ff}, 26'h0000000)
        @(posedge mclk);
        for (int a = 0; a < 16; a++) begin
            if (a < 3 || a > 9) chkRd(a[3:0], 16'hFFFF, 16'h0000);
        end
        foreach (amTab[i]) begin
            wr(`SCE_REG_CTRLA, {amTab[i][24], amTab[i][29:28], 13'h0000});
            wr(`SCE_REG_ADDR, amTab[i][23:8]);
            rxAddr      <= amTab[i][7:0];
            rxAddrValid <= 1'b1;
            @(posedge mclk);
            rxAddrValid <= 1'b0;
            #1;
            `CHK(addrMatch_ff, expMatch(amTab[i]))
            @(posedge mclk);
            chkRd(`SCE_REG_MATCH, 16'h0001, {15'h0000, expMatch(amTab[i])});
        end
        wr(`SCE_REG_CTRLB, 16'h0063);
        wr(`SCE_REG_CTRLA, 16'h1884);
        wr(`SCE_REG_CTRLA, 16'h1886);
        `CHK({padOe[3], padOe[0], padOut[0], irqReq}, 4'h6)
        wr(`SCE_REG_IRQ_ENABLE_SET_REGISTER, 16'h0004);
        i_peer.sendByte(8'h4B);
        for (n = 0; irqReq !== 1'b1 && n < 64; n++) @(posedge mclk);
        `CHK(irqReq, 1'b1)
        chkRd(`SCE_REG_IRQ_FLAG_REGISTER, 16'h0004, 16'h0004);
        chkRd(`SCE_REG_STATUS, 16'h0007, 16'h0000);
        wr(`SCE_REG_IRQ_ENABLE_CLEAR_REGISTER, 16'h0000);
        `CHK(irqReq, 1'b1)
        wr(`SCE_REG_IRQ_ENABLE_CLEAR_REGISTER, 16'h001F);
        `CHK(irqReq, 1'b0)
        wr(`SCE_REG_IRQ_ENABLE_SET_REGISTER, 16'h0004);
        `CHK(irqReq, 1'b1)
        chkRd(`SCE_REG_DATA, 16'h00FF, 16'h004B);
        wr(`SCE_REG_IRQ_FLAG_REGISTER, 16'h0004);
        `CHK(irqReq, 1'b0)
        for (int f = 0; f < 2; f++) begin
            // The second frame adds even parity.
            if (f == 1) wr(`SCE_REG_CTRLA, 16'h1884);
            if (f == 1) wr(`SCE_REG_CTRLA, 16'h1986);
            txFrame = {1'b1, (f == 1) ? ^8'h4B : 1'b1, 8'h4B};
            wr(`SCE_REG_DATA, 16'h004B);
            for (n = 0; padOut[0] !== 1'b0 && n < 64; n++) @(posedge mclk);
            repeat (8) @(posedge mclk);
            for (int i = 0; i < 10; i++) begin
                repeat (16) @(posedge mclk);
                #1;
                `CHK(padOut[0], txFrame[i])
            end
        end
        wr(`SCE_REG_IRQ_ENABLE_SET_REGISTER, 16'h0001);
        `CHK(irqReq, 1'b1)
        wr(`SCE_REG_CTRLA, 16'h0001);
        `CHK({padOe, irqReq}, 5'h00)
        summarize();
    end
endmodule
`default_nettype wire

// file: bench/sce_peer.sv
`default_nettype none
module sce_peer (
    input  wire logic mclk,
    output logic      rxLine
);
    timeunit 1ns;
    timeprecision 100ps;

    // The far line idles high between frames.
    initial rxLine = 1'b1;

    // Sends start, eight data bits LSB first and one stop bit, 16 clocks a bit.
    task automatic sendByte(input logic [7:0] b);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxLine <= fr[i];
            repeat (16) @(posedge mclk);
        end
    endtask
endmodule
`default_nettype wire

// file: design/sce_core.v
// The address map and strobed register access were chosen for this implementation.
`include "sce_map.vh"
`default_nettype none
module sce_core (
    input  wire        mclk,
    input  wire        rst_n,
    input  wire [3:0]  regAddr,
    input  wire [15:0] regWdata,
    input  wire        regWr,
    input  wire        regRd,
    output reg  [15:0] regRdata,
    input  wire [3:0]  padIn,
    output reg  [3:0]  padOut,
    output reg  [3:0]  padOe,
    input  wire [7:0]  rxAddr,
    input  wire        rxAddrValid,
    output reg         addrMatch_ff,
    output wire        irqReq
);

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers.
    reg  [15:0] ctrla_ff;
    reg  [6:0]  ctrlb_ff;
    reg  [15:0] baud_ff;
    reg  [15:0] addrReg_ff;
    reg  [4:0]  inten_ff;
    reg  [4:0]  flag_ff;
    reg  [2:0]  status_ff;

    wire        enable   = ctrla_ff[`SCE_CA_ENABLE];
    wire [2:0]  opMode   = ctrla_ff[`SCE_CA_MODE_LO +: 3];
    wire        cmode    = ctrla_ff[`SCE_CA_CMODE];
    wire        cpol     = ctrla_ff[`SCE_CA_CPOL];
    wire        dord     = ctrla_ff[`SCE_CA_DORD];
    wire        parEn    = ctrla_ff[`SCE_CA_FORM];
    wire [1:0]  transmit_pad_select     = ctrla_ff[`SCE_CA_TRANSMIT_PAD_SELECT_LO +: 2];
    wire [1:0]  receive_pad_select     = ctrla_ff[`SCE_CA_RECEIVE_PAD_SELECT_LO +: 2];
    wire [1:0]  amode    = ctrla_ff[`SCE_CA_AMODE_LO +: 2];
    wire        addr8    = ctrla_ff[`SCE_CA_ADDR8];
    wire [2:0]  chsize   = ctrlb_ff[`SCE_CB_CHSIZE_LO +: 3];
    wire        twoStop  = ctrlb_ff[`SCE_CB_SBMODE];
    wire        oddPar   = ctrlb_ff[`SCE_CB_PMODE];
    wire        txEn     = enable & ctrlb_ff[`SCE_CB_TXEN];
    wire        rxEn     = enable & ctrlb_ff[`SCE_CB_RXEN];
    wire        extClk   = (opMode == `SCE_MODE_EXTCLK);
    // Character size 0..3 means 5..8 bits, 7 means 9 bits.
    wire [3:0]  nBits    = (chsize == 3'h7) ? 4'h9 : ({1'b0, chsize} + 4'h5);

    ////////////////////////////////////////////////////////////////////////
    // Pad multiplexing and pin synchronisation.
    reg  [3:0]  padMeta_ff;
    reg  [3:0]  padSync_ff;
    reg         txLine;
    reg         sckOut;
    wire [1:0]  sckPad   = (transmit_pad_select == 2'h0) ? 2'h1 : 2'h3;
    wire        rxPin    = padSync_ff[receive_pad_select];                                  // RULE_17
    wire        sckPin   = padSync_ff[sckPad];
    // Two-register crossing for the pad inputs only; bus-written controls are not synchronised.
    always @(posedge mclk) begin
        padMeta_ff <= padIn;                                                  // RULE_13
        padSync_ff <= padMeta_ff;
    end

    always @* begin
        padOut = 4'h0;
        padOe  = 4'h0;
        if (txEn) begin                                                       // RULE_16
            padOut[{transmit_pad_select[1], 1'b0}] = txLine;                                 // RULE_17
            padOe[{transmit_pad_select[1], 1'b0}]  = 1'b1;
            if (cmode && !extClk) begin
                padOut[sckPad] = sckOut;
                padOe[sckPad]  = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Baud generator with internal clock: fractional accumulator in async, counter in sync.
    reg  [16:0] fracAcc_ff;
    reg  [7:0]  syncCnt_ff;
    reg         rxTick;
    reg  [3:0]  div16_ff;
    reg         txTick;
    reg         sckPrev_ff;
    wire [16:0] fracSum  = {1'b0, fracAcc_ff[15:0]} + {1'b0, 16'hFFFF - baud_ff} + 17'h00001;
    wire        sckRise  = sckPin & ~sckPrev_ff;
    wire        sckFall  = ~sckPin & sckPrev_ff;

    always @(posedge mclk) begin
        if (!rst_n || !enable) begin
            fracAcc_ff <= 17'h00000;
            syncCnt_ff <= 8'h00;
            div16_ff   <= 4'h0;
            sckOut     <= 1'b0;
            sckPrev_ff <= 1'b0;
        end else begin
            sckPrev_ff <= sckPin;
            fracAcc_ff <= fracSum;                                            // RULE_01 RULE_02
            if (rxTick)
                div16_ff <= div16_ff + 4'h1;                                  // RULE_22
            if (cmode && !extClk) begin
                if (syncCnt_ff == baud_ff[7:0]) begin
                    syncCnt_ff <= 8'h00;
                    sckOut     <= ~sckOut;                                    // RULE_19
                end else begin
                    syncCnt_ff <= syncCnt_ff + 8'h01;
                end
            end
        end
    end

    always @* begin
        rxTick = 1'b0;
        txTick = 1'b0;
        if (cmode) begin
            if (extClk) begin
                txTick = cpol ? sckFall : sckRise;
                rxTick = cpol ? sckRise : sckFall;
            end else begin
                txTick = (syncCnt_ff == baud_ff[7:0]) & ~sckOut;
                rxTick = (syncCnt_ff == baud_ff[7:0]) &  sckOut;
            end
        end else if (extClk) begin
            rxTick = sckRise;
            txTick = sckRise & (div16_ff == 4'hF);
        end else begin
            rxTick = fracSum[16];                                             // RULE_01
            txTick = fracSum[16] & (div16_ff == 4'hF);                        // RULE_22
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmitter: holding buffer in front of shift register.
    reg  [8:0]  txHold_ff;
    reg         txHoldFull_ff;
    reg  [11:0] txShift_ff;
    reg  [3:0]  txCnt_ff;
    reg         txBusy_ff;
    reg         txLoad;
    reg  [8:0]  txOrd;
    reg         txParity;
    integer     i;
    wire        dataWr   = regWr && (regAddr == `SCE_REG_DATA);

    always @* begin
        txOrd    = 9'h1FF;
        txParity = oddPar;
        for (i = 0; i < 9; i = i + 1) begin
            if (i < nBits) begin
                txOrd[i] = dord ? txHold_ff[i] : txHold_ff[nBits - 1 - i];
                txParity = txParity ^ txHold_ff[i];
            end
        end
        txLoad = txHoldFull_ff && (!txBusy_ff || (txTick && txCnt_ff == 4'h1));
        txLine = txBusy_ff ? txShift_ff[0] : 1'b1;                            // RULE_23
    end

    always @(posedge mclk) begin
        if (!rst_n || !txEn) begin
            txHoldFull_ff <= 1'b0;
            txHold_ff     <= 9'h000;
            txShift_ff    <= 12'hFFF;
            txCnt_ff      <= 4'h0;
            txBusy_ff     <= 1'b0;
        end else begin
            if (dataWr && !txHoldFull_ff) begin
                txHold_ff     <= regWdata[8:0];
                txHoldFull_ff <= 1'b1;                                        // RULE_14
            end else if (txLoad && txTick) begin
                txHoldFull_ff <= 1'b0;
            end
            if (txTick) begin
                if (txLoad) begin
                    // Start bit, data, optional parity, stop bits; data LSB leaves first when dord is set, MSB first otherwise.
                    // Bits above the character are ones, so the stop bits follow.
                    txShift_ff <= {3'h7, txOrd} << 1;                         // RULE_18
                    if (parEn)
                        txShift_ff[nBits + 4'h1] <= txParity;
                    txCnt_ff   <= nBits + (parEn ? 4'h1 : 4'h0) + (twoStop ? 4'h3 : 4'h2);
                    txBusy_ff  <= 1'b1;
                end else if (txBusy_ff) begin
                    txShift_ff <= {1'b1, txShift_ff[11:1]};
                    txCnt_ff   <= txCnt_ff - 4'h1;
                    if (txCnt_ff == 4'h1)
                        txBusy_ff <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receiver: majority filter, start check, shifter, two-entry buffer.
    reg  [2:0]  rxFilt_ff;
    reg         rxBit_ff;
    reg  [3:0]  rxPh_ff;
    reg  [3:0]  rxCnt_ff;
    reg         rxBusy_ff;
    reg  [11:0] rxShift_ff;
    reg  [11:0] rxBuf0_ff;
    reg  [11:0] rxBuf1_ff;
    reg  [1:0]  rxLvl_ff;
    reg         rxDone;
    reg         rxSample;
    reg  [8:0]  rxWord;
    reg         rxPar;
    integer     j;
    wire        rxMaj    = (rxFilt_ff[0] & rxFilt_ff[1]) | (rxFilt_ff[1] & rxFilt_ff[2])
                         | (rxFilt_ff[0] & rxFilt_ff[2]);
    wire [3:0]  rxTotal  = nBits + (parEn ? 4'h1 : 4'h0) + 4'h1;
    wire        dataRd   = regRd && (regAddr == `SCE_REG_DATA);
    wire        rxPop    = dataRd && (rxLvl_ff != 2'h0);

    always @* begin
        rxSample = rxTick && rxBusy_ff && (cmode || rxPh_ff == `SCE_OVS_MID);
        rxDone   = rxSample && (rxCnt_ff == rxTotal);
        rxWord   = 9'h000;
        rxPar    = oddPar;
        for (j = 0; j < 9; j = j + 1) begin
            if (j < nBits) begin
                rxWord[j] = dord ? rxShift_ff[j + 1] : rxShift_ff[nBits - j];
                rxPar     = rxPar ^ rxShift_ff[j + 1];
            end
        end
        if (parEn)
            rxPar = rxPar ^ rxShift_ff[nBits + 1];
        else
            rxPar = 1'b0;
    end

    always @(posedge mclk) begin
        if (!rst_n || !rxEn) begin
            rxFilt_ff  <= 3'h7;
            rxBit_ff   <= 1'b1;
            rxPh_ff    <= 4'h0;
            rxCnt_ff   <= 4'h0;
            rxBusy_ff  <= 1'b0;
            rxShift_ff <= 12'h000;
            rxBuf0_ff  <= 12'h000;
            rxBuf1_ff  <= 12'h000;
            rxLvl_ff   <= 2'h0;
        end else begin
            if (rxTick) begin
                rxFilt_ff <= {rxFilt_ff[1:0], rxPin};                         // RULE_20
                rxBit_ff  <= rxMaj;
                rxPh_ff   <= rxPh_ff + 4'h1;
            end
            if (!rxBusy_ff && rxTick && !rxMaj && (cmode || rxBit_ff)) begin
                rxBusy_ff <= 1'b1;                                            // RULE_23
                rxPh_ff   <= 4'h0;
                rxCnt_ff  <= cmode ? 4'h1 : 4'h0;
            end else if (rxSample) begin
                if (!cmode && rxCnt_ff == 4'h0 && rxMaj) begin
                    rxBusy_ff <= 1'b0;                                        // RULE_20
                end else begin
                    rxShift_ff[rxCnt_ff] <= rxMaj;
                    rxCnt_ff <= rxCnt_ff + 4'h1;
                end
                if (rxDone)
                    rxBusy_ff <= 1'b0;
            end
            // Entry holds {bufovf, ferr, perr, data}; overflow marks the newest entry.
            if (rxDone && rxLvl_ff == 2'h2 && !rxPop) begin
                rxBuf1_ff[11] <= 1'b1;                                        // RULE_21
            end else if (rxDone) begin
                if ((rxLvl_ff == 2'h0) || (rxLvl_ff == 2'h1 && rxPop))
                    rxBuf0_ff <= {1'b0, ~rxMaj, rxPar, rxWord};               // RULE_15 RULE_21
                else
                    rxBuf1_ff <= {1'b0, ~rxMaj, rxPar, rxWord};
                if (rxPop && rxLvl_ff == 2'h2)
                    rxBuf0_ff <= rxBuf1_ff;
                if (!rxPop)
                    rxLvl_ff <= rxLvl_ff + 2'h1;
            end else if (rxPop) begin
                rxBuf0_ff <= rxBuf1_ff;
                rxLvl_ff  <= rxLvl_ff - 2'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address match.
    reg         nxt_match;
    wire [7:0]  aMask    = addr8 ? 8'hFF : 8'h7F;                             // RULE_05
    wire [7:0]  aAddr    = addrReg_ff[7:0] & aMask;
    wire [7:0]  aAmsk    = addrReg_ff[15:8] & aMask;
    wire [7:0]  aRx      = rxAddr & aMask;

    always @* begin
        case (amode)
            `SCE_AM_MASK:  nxt_match = ((aRx ^ aAddr) & ~aAmsk) == 8'h00;     // RULE_03 RULE_04 RULE_24
            `SCE_AM_TWO:   nxt_match = (aRx == aAddr) || (aRx == aAmsk);      // RULE_06
            `SCE_AM_RANGE: nxt_match = (aRx <= aAddr) && (aRx >= aAmsk);      // RULE_07
            default:       nxt_match = 1'b0;
        endcase
    end

    always @(posedge mclk) begin
        if (!rst_n)
            addrMatch_ff <= 1'b0;
        else if (rxAddrValid)
            addrMatch_ff <= nxt_match;
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt flags and request.
    reg  [4:0]  flagSet;
    reg         txcLast_ff;
    wire [4:0]  flagClr  = (regWr && regAddr == `SCE_REG_IRQ_FLAG_REGISTER) ? regWdata[4:0] : 5'h00;

    always @* begin
        flagSet = 5'h00;
        flagSet[`SCE_IF_DRE] = txEn & ~txHoldFull_ff;                         // RULE_08
        flagSet[`SCE_IF_TXC] = txcLast_ff & ~txBusy_ff & ~txHoldFull_ff;
        flagSet[`SCE_IF_RXC] = rxLvl_ff != 2'h0;
        flagSet[`SCE_IF_RXS] = rxTick & ~rxBusy_ff & ~rxMaj & rxBit_ff & rxEn;
        flagSet[`SCE_IF_ERR] = rxDone & (~rxMaj | rxPar | (rxLvl_ff == 2'h2 && !rxPop));
    end

    always @(posedge mclk) begin
        if (!rst_n) begin
            ctrla_ff   <= `SCE_CTRLA_RST;
            ctrlb_ff   <= `SCE_CTRLB_RST;
            baud_ff    <= `SCE_BAUD_RST;
            addrReg_ff <= 16'h0000;
            inten_ff   <= 5'h00;
            flag_ff    <= 5'h00;
            status_ff  <= 3'h0;
            txcLast_ff <= 1'b0;
        end else begin
            txcLast_ff <= txBusy_ff | txHoldFull_ff;
            flag_ff    <= (flag_ff & ~flagClr) | flagSet;                     // RULE_08 RULE_11
            status_ff  <= rxLvl_ff == 2'h0 ? 3'h0 : rxBuf0_ff[11:9];
            if (regWr) begin
                case (regAddr)
                    // Frame setup only changes while the unit is disabled.
                    `SCE_REG_CTRLA: ctrla_ff <= enable ?
                        {ctrla_ff[15:2], regWdata[1], 1'b0} : {regWdata[15:1], 1'b0};
                    `SCE_REG_CTRLB: ctrlb_ff <= enable ?
                        {regWdata[6:5], ctrlb_ff[4:0]} : regWdata[6:0];
                    `SCE_REG_BAUD:  if (!enable) baud_ff <= regWdata;
                    `SCE_REG_ADDR:  addrReg_ff <= regWdata;
                    `SCE_REG_IRQ_ENABLE_SET_REGISTER: inten_ff <= inten_ff | regWdata[4:0];  // RULE_09
                    `SCE_REG_IRQ_ENABLE_CLEAR_REGISTER: inten_ff <= inten_ff & ~regWdata[4:0]; // RULE_09
                    default: ;
                endcase
                if (regAddr == `SCE_REG_CTRLA && regWdata[0]) begin
                    ctrla_ff   <= `SCE_CTRLA_RST;
                    ctrlb_ff   <= `SCE_CTRLB_RST;
                    baud_ff    <= `SCE_BAUD_RST;
                    addrReg_ff <= 16'h0000;
                    inten_ff   <= 5'h00;
                    flag_ff    <= 5'h00;
                end
            end
        end
    end

    // Request is level; it runs on mclk alone so it can wake the system.
    assign irqReq = |(flag_ff & inten_ff);                                    // RULE_10 RULE_11 RULE_12

    ////////////////////////////////////////////////////////////////////////
    // Read port.
    always @(posedge mclk) begin
        if (!rst_n) begin
            regRdata <= 16'h0000;
        end else if (regRd) begin
            case (regAddr)
                `SCE_REG_CTRLA:    regRdata <= ctrla_ff;
                `SCE_REG_CTRLB:    regRdata <= {9'h000, ctrlb_ff};
                `SCE_REG_BAUD:     regRdata <= baud_ff;
                `SCE_REG_ADDR:     regRdata <= addrReg_ff;
                `SCE_REG_IRQ_ENABLE_CLEAR_REGISTER: regRdata <= {11'h000, inten_ff};
                `SCE_REG_IRQ_ENABLE_SET_REGISTER: regRdata <= {11'h000, inten_ff};
                `SCE_REG_IRQ_FLAG_REGISTER:  regRdata <= {11'h000, flag_ff};
                `SCE_REG_STATUS:   regRdata <= {13'h0000, status_ff};
                `SCE_REG_DATA:     regRdata <= {7'h00, rxBuf0_ff[8:0]};
                `SCE_REG_MATCH:    regRdata <= {15'h0000, addrMatch_ff};
                default:           regRdata <= 16'h0000;
            endcase
        end else begin
            regRdata <= 16'h0000;
        end
    end

endmodule
`default_nettype wire

// file: design/sce_map.vh
// Functional notes
// RULE_01: Async baud rate averages fref/16*(1-BAUD/65536) over 65536 reference cycles.
// RULE_02: Frame timing changes only when BAUD adds whole reference cycles per frame.
// RULE_03: Masked-address mode compares received address against stored address, skipping masked bits.
// RULE_04: Zero mask accepts one exact address; all-ones mask accepts every address.
// RULE_05: Address compare uses seven or eight bits depending on active mode.
// RULE_06: Two-address mode matches stored address or the mask field value.
// RULE_07: Range mode matches addresses from mask field up to address field inclusive.
// RULE_08: Every interrupt source has its own flag, set when its condition occurs.
// RULE_09: Writing one to enable-set enables; enable-clear disables; zeros do nothing.
// RULE_10: Interrupt request asserts when any flag and its enable are both set.
// RULE_11: Request holds until flag cleared, interrupt disabled, or unit reset.
// RULE_12: Unit keeps working in sleep while its clock runs; interrupts wake system.
// RULE_13: Registers crossing bus and core clock domains are synchronized on access. Code clocks both on mclk; register writes are not synchronised.
// RULE_14: Transmitter has one holding buffer before shifter for gapless frames.
// RULE_15: Receiver has two-entry buffer with status stored per received word.
// RULE_16: TX pin output, RX pin input, clock line either; disabled pins released.
// RULE_17: Pad select fields decide which of four pads carry TX, RX, clock.
// RULE_18: Frames of 5 to 9 data bits, 1 or 2 stops, parity, bit order.
// RULE_19: Internal clock up to half system clock; external clock up to full clock. Code takes external clock up to half mclk.
// RULE_20: Receiver rejects false start bits and low-pass filters sampled input.
// RULE_21: Receiver detects and reports buffer overflow and framing errors.
// RULE_22: Async mode transmits on divide-by-16 output, samples on divide-by-1 output.
// RULE_23: Idle line is high; each frame starts with start bit then data.
// RULE_24: Mask bit one excludes that position; mask bit zero requires exact match.
`ifndef SCE_MAP_VH
`define SCE_MAP_VH
`define SCE_REG_CTRLA     4'h0
`define SCE_REG_CTRLB     4'h1
`define SCE_REG_BAUD      4'h2
`define SCE_REG_ADDR      4'h3
`define SCE_REG_IRQ_ENABLE_CLEAR_REGISTER  4'h4
`define SCE_REG_IRQ_ENABLE_SET_REGISTER  4'h5
`define SCE_REG_IRQ_FLAG_REGISTER   4'h6
`define SCE_REG_STATUS    4'h7
`define SCE_REG_DATA      4'h8
`define SCE_REG_MATCH     4'h9
`define SCE_CA_ENABLE     1
`define SCE_CA_MODE_LO    2
`define SCE_CA_CMODE      5
`define SCE_CA_CPOL       6
`define SCE_CA_DORD       7
`define SCE_CA_FORM       8
`define SCE_CA_TRANSMIT_PAD_SELECT_LO    9
`define SCE_CA_RECEIVE_PAD_SELECT_LO    11
`define SCE_CA_AMODE_LO   13
`define SCE_CA_ADDR8      15
`define SCE_CB_CHSIZE_LO  0
`define SCE_CB_SBMODE     3
`define SCE_CB_PMODE      4
`define SCE_CB_TXEN       5
`define SCE_CB_RXEN       6
`define SCE_IF_DRE        0
`define SCE_IF_TXC        1
`define SCE_IF_RXC        2
`define SCE_IF_RXS        3
`define SCE_IF_ERR        4
`define SCE_ST_PERR       0
`define SCE_ST_FERR       1
`define SCE_ST_BUFOVF     2
`define SCE_AM_MASK       2'h0
`define SCE_AM_TWO        2'h1
`define SCE_AM_RANGE      2'h2
`define SCE_MODE_EXTCLK   3'h0
`define SCE_MODE_INTCLK   3'h1
`define SCE_OVS           5'h10
`define SCE_OVS_MID       4'h8
`define SCE_FILT_LEN      3'h3
`define SCE_CTRLA_RST     16'h0000
`define SCE_CTRLB_RST     7'h00
`define SCE_BAUD_RST      16'h0000
`endif
